/* logic/zbu_pkg.sv */
// Constants, enumerations and carriers shared by the zone bus unit.
// Assumes a 24-bit core address space and 16-bit zone configuration words.
package zbu_pkg;

  // ****************************************************************
  // Widths and register indexes (byte address is four times index).
  // ****************************************************************
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam logic [23:0] BUS_CFG_IDX = 24'hff_f900;
  localparam logic [23:0] IO_CFG_IDX = 24'hff_f902;
  localparam logic [23:0] SZA_CFG_IDX = 24'hff_f904;
  localparam logic [23:0] SZB_CFG_IDX = 24'hff_f906;
  localparam logic [23:0] SZC_CFG_IDX = 24'hff_f908;
  localparam logic [23:0] MODE_STAT_IDX = 24'hff_f90a;

  // ****************************************************************
  // Reset values and field positions.
  // ****************************************************************
  localparam logic [7:0] BUS_CFG_RST = 8'h07;
  localparam logic [15:0] ZONE_CFG_RST = 16'h069f;
  localparam int unsigned EARLY_WR_BIT = 0;
  localparam int unsigned WAIT_LSB = 0;
  localparam int unsigned HOLD_LSB = 3;
  localparam int unsigned FAST_RD_BIT = 11;

  // ****************************************************************
  // Address map bounds.
  // ****************************************************************
  localparam logic [23:0] Z0_HI = 24'h03_ffff;
  localparam logic [23:0] Z1_LO = 24'h40_0000;
  localparam logic [23:0] Z1_HI = 24'h7f_ffff;
  localparam logic [23:0] Z2_LO = 24'h80_0000;
  localparam logic [23:0] Z2_HI = 24'hfe_ffff;
  localparam logic [23:0] IO_LO = 24'hff_fb00;
  localparam logic [23:0] IO_HI = 24'hff_fbff;

  // ****************************************************************
  // Basic bus cycle lengths in clocks, before wait and hold.
  // ****************************************************************
  localparam logic [4:0] FAST_RD_CYC = 5'h01;
  localparam logic [4:0] NORM_RD_CYC = 5'h02;
  localparam logic [4:0] LATE_WR_CYC = 5'h02;
  localparam logic [4:0] EARLY_WR_CYC = 5'h03;

  // ****************************************************************
  // Boot mode pin codes and select bit positions.
  // ****************************************************************
  localparam logic [2:0] BOOT_IRE = 3'h7;
  localparam logic [2:0] BOOT_ERE = 3'h3;
  localparam logic [2:0] BOOT_ISP = 3'h6;
  localparam logic [2:0] BOOT_DEV = 3'h0;
  localparam int unsigned SEL_Z0 = 0;
  localparam int unsigned SEL_Z1 = 1;
  localparam int unsigned SEL_Z2 = 2;
  localparam int unsigned SEL_IO = 3;

  typedef enum logic [1:0] {
    ZBU_IRE = 2'b00,
    ZBU_ERE = 2'b01,
    ZBU_DEV = 2'b10,
    ZBU_ISP = 2'b11
  } zbu_mode_e;

  typedef enum logic [2:0] {
    ZN_NONE = 3'b000,
    ZN_S0 = 3'b001,
    ZN_S1 = 3'b010,
    ZN_S2 = 3'b011,
    ZN_IO = 3'b100
  } zbu_zone_e;

  typedef enum logic [2:0] {
    ZS_IDLE = 3'b000,
    ZS_ADDR = 3'b001,
    ZS_WAIT = 3'b010,
    ZS_XFER = 3'b011,
    ZS_HOLD = 3'b100
  } zbu_state_e;

  typedef struct packed {
    logic valid;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
  } zbu_core_req_s;

  typedef struct packed {
    logic [3:0] sel;
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } zbu_mem_bus_s;

endpackage

/* logic/zbu_zone_bus_unit.sv */
// Zone bus unit: decodes core accesses into zones and runs timed bus cycles.
// Assumes one clock, synchronous reset, a classic Wishbone register master
// and a core master that holds its request until the done pulse.
//
// Notes on behaviour
// - Flat 16M space decoded into configured zones.
// - 000000h-03FFFFh decodes to static zone 0.
// - 400000h-7FFFFFh goes external as zone 1.
// - 800000h-FEFFFFh goes external as zone 2.
// - FFFB00h-FFFBFFh runs as I/O zone cycles.
// - Pins 111 give internal flash, blank gives programming.
// - Pins 011 give external code, blank gives programming.
// - Pins 110 always give programming mode.
// - Pins 000 redirect zone 0 to external bus.
// - Boot pins sampled on the first edge after reset, floating reads ones.
// - External memory only when mode allows it.
// - Normal read two clocks, fast read one.
// - Reads start normal after reset.
// - Late write two clocks, early write three.
// - Cycle type from direction, zone and timing.
// - Wait cycles follow the address phase.
// - Hold cycles keep data driven at end.
// - Write config resets 07h, bit 0 early.
// - Bus strobes follow the zone parameters.
// - Zero to seven wait cycles from field.
// - Zero to three hold cycles from field.
`timescale 1ns/1ps

module zbu_zone_bus_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [25:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Boot straps.
  input wire logic [2:0] boot_mode_pins_i,
  input wire logic flash_blank_i,
  // Core bus.
  input wire zbu_pkg::zbu_core_req_s core_req_i,
  output logic core_stall_o,
  output logic core_done_o,
  output logic [15:0] core_rdata_o,
  // On-chip flash and external bus.
  output zbu_pkg::zbu_mem_bus_s flash_bus_o,
  input wire logic [15:0] flash_rdata_i,
  output zbu_pkg::zbu_mem_bus_s ext_bus_o,
  input wire logic [15:0] ext_data_i,
  output logic ext_data_oe_n_o
);
  import zbu_pkg::*;

  // ****************************************************************
  // Configuration registers and Wishbone slave.
  // ****************************************************************
  logic [7:0] bus_write_timing_config_r;
  logic [15:0] zone_cfg_r [4];
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic [23:0] wb_idx;
  logic wb_wr;
  logic [15:0] rd_mux;
  zbu_mode_e mode_r;
  logic [2:0] pins_r;
  logic strap_done_r;

  assign wb_idx = wb_adr_i[25:2];
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_r;
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // Read mux; unmapped indexes read as zero but are still acknowledged.
  always_comb begin
    rd_mux = 16'h0000;
    unique case (wb_idx)
      BUS_CFG_IDX: rd_mux = {8'h00, bus_write_timing_config_r};
      IO_CFG_IDX: rd_mux = zone_cfg_r[0];
      SZA_CFG_IDX: rd_mux = zone_cfg_r[1];
      SZB_CFG_IDX: rd_mux = zone_cfg_r[2];
      SZC_CFG_IDX: rd_mux = zone_cfg_r[3];
      MODE_STAT_IDX: rd_mux = {11'h000, pins_r, mode_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Ack one cycle after the request; it drops in the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
      if (wb_cyc_i && wb_stb_i && !wb_ack_r) begin
        wb_dat_r <= {16'h0000, rd_mux};
      end
    end
  end

  // The write takes effect on the edge where the master sees ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_write_timing_config_r <= BUS_CFG_RST;
    end else if (wb_wr && wb_sel_i[0] && wb_idx == BUS_CFG_IDX) begin
      bus_write_timing_config_r <= wb_dat_i[7:0];
    end
  end

  // Zone timing words, byte lane writable; normal reads after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        zone_cfg_r[i] <= ZONE_CFG_RST;
      end
    end else if (wb_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_idx == IO_CFG_IDX + 24'(2 * i)) begin
          if (wb_sel_i[0]) begin
            zone_cfg_r[i][7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            zone_cfg_r[i][15:8] <= wb_dat_i[15:8];
          end
        end
      end
    end
  end

  // ****************************************************************
  // Operating environment.
  // ****************************************************************
  // Straps are caught on the first edge after reset release, never by reset itself.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_r <= 1'b0;
      mode_r <= ZBU_ISP;
      pins_r <= 3'h7;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      pins_r <= boot_mode_pins_i;
      unique case (boot_mode_pins_i)
        BOOT_IRE: mode_r <= flash_blank_i ? ZBU_ISP : ZBU_IRE;
        BOOT_ERE: mode_r <= flash_blank_i ? ZBU_ISP : ZBU_ERE;
        BOOT_DEV: mode_r <= ZBU_DEV;
        BOOT_ISP: mode_r <= ZBU_ISP;
        default: mode_r <= ZBU_ISP;
      endcase
    end
  end

  // ****************************************************************
  // Address decode and cycle parameters.
  // ****************************************************************
  zbu_zone_e zone_d;
  logic [15:0] cfg_d;
  logic ext_ok;
  logic fast_d;
  logic early_d;
  logic [2:0] wait_d;
  logic [1:0] hold_d;
  logic [4:0] exp_d;
  logic accept;

  // External memory is only reachable where the mode permits it.
  assign ext_ok = (mode_r == ZBU_ERE) || (mode_r == ZBU_DEV);

  // Every address falls into one zone or none.
  always_comb begin
    zone_d = ZN_NONE;
    if (core_req_i.addr <= Z0_HI) begin
      zone_d = ZN_S0;
    end else if (core_req_i.addr >= Z1_LO && core_req_i.addr <= Z1_HI && ext_ok) begin
      zone_d = ZN_S1;
    end else if (core_req_i.addr >= Z2_LO && core_req_i.addr <= Z2_HI && ext_ok) begin
      zone_d = ZN_S2;
    end else if (core_req_i.addr >= IO_LO && core_req_i.addr <= IO_HI) begin
      zone_d = ZN_IO;
    end
  end

  // Cycle type comes from direction, zone and programmed timing.
  always_comb begin
    unique case (zone_d)
      ZN_S0: cfg_d = zone_cfg_r[1];
      ZN_S1: cfg_d = zone_cfg_r[2];
      ZN_S2: cfg_d = zone_cfg_r[3];
      default: cfg_d = zone_cfg_r[0];
    endcase
    fast_d = !core_req_i.we && zone_d != ZN_IO && cfg_d[FAST_RD_BIT];
    early_d = core_req_i.we && bus_write_timing_config_r[EARLY_WR_BIT];
    wait_d = fast_d ? 3'h0 : cfg_d[WAIT_LSB +: 3];
    hold_d = fast_d ? 2'h0 : cfg_d[HOLD_LSB +: 2];
    if (zone_d == ZN_NONE) begin
      exp_d = 5'h00;
    end else begin
      exp_d = (fast_d ? FAST_RD_CYC : core_req_i.we ?
               (early_d ? EARLY_WR_CYC : LATE_WR_CYC) : NORM_RD_CYC)
              + 5'(wait_d) + 5'(hold_d);
    end
  end

  // ****************************************************************
  // Bus cycle sequencer.
  // ****************************************************************
  zbu_state_e st_r;
  zbu_zone_e zone_r;
  logic [2:0] cnt_r;
  logic [2:0] wait_r;
  logic [1:0] hold_r;
  logic we_r;
  logic fast_r;
  logic [23:0] addr_r;
  logic [15:0] wdata_r;
  logic done_r;
  logic [15:0] rdata_r;
  logic z0_ext;

  assign accept = st_r == ZS_IDLE && core_req_i.valid && !done_r && strap_done_r;
  assign z0_ext = mode_r == ZBU_DEV;

  // A request is latched once; reserved ranges end at once with no bus cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ZS_IDLE;
      zone_r <= ZN_NONE;
      cnt_r <= 3'h0;
      wait_r <= 3'h0;
      hold_r <= 2'h0;
      we_r <= 1'b0;
      fast_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        ZS_IDLE: begin
          if (accept) begin
            zone_r <= zone_d;
            we_r <= core_req_i.we;
            fast_r <= fast_d;
            wait_r <= wait_d;
            hold_r <= hold_d;
            if (zone_d == ZN_NONE) begin
              done_r <= 1'b1;
            end else if (fast_d) begin
              st_r <= ZS_XFER;
            end else begin
              st_r <= ZS_ADDR;
              cnt_r <= early_d ? 3'h1 : 3'h0;
            end
          end
        end
        ZS_ADDR: begin
          if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
          end else if (wait_r != 3'h0) begin
            st_r <= ZS_WAIT;
            cnt_r <= wait_r - 3'h1;
          end else begin
            st_r <= ZS_XFER;
          end
        end
        ZS_WAIT: begin
          if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
          end else begin
            st_r <= ZS_XFER;
          end
        end
        ZS_XFER: begin
          if (hold_r != 2'h0) begin
            st_r <= ZS_HOLD;
            cnt_r <= 3'(hold_r - 2'h1);
          end else begin
            st_r <= ZS_IDLE;
            done_r <= 1'b1;
          end
        end
        ZS_HOLD: begin
          if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
          end else begin
            st_r <= ZS_IDLE;
            done_r <= 1'b1;
          end
        end
        default: st_r <= ZS_IDLE;
      endcase
    end
  end

  // Address, write data and read data are held in flip-flops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_r <= 24'h00_0000;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
    end else begin
      if (accept) begin
        addr_r <= core_req_i.addr;
        wdata_r <= core_req_i.wdata;
        rdata_r <= 16'h0000;
      end
      if (st_r == ZS_XFER && !we_r) begin
        rdata_r <= (zone_r == ZN_S0 && !z0_ext) ? flash_rdata_i : ext_data_i;
      end
    end
  end

  // The core waits from acceptance until the done pulse.
  assign core_stall_o = (st_r != ZS_IDLE) || accept;
  assign core_done_o = done_r;
  assign core_rdata_o = rdata_r;

  // Strobes follow the sequencer; internal zone 0 never toggles the pins.
  always_comb begin
    logic [3:0] sel;
    logic act;
    sel = 4'h0;
    act = st_r != ZS_IDLE;
    unique case (zone_r)
      ZN_S0: sel[SEL_Z0] = act;
      ZN_S1: sel[SEL_Z1] = act;
      ZN_S2: sel[SEL_Z2] = act;
      ZN_IO: sel[SEL_IO] = act;
      default: sel = 4'h0;
    endcase
    flash_bus_o = '0;
    ext_bus_o = '0;
    if (zone_r == ZN_S0 && !z0_ext) begin
      flash_bus_o.sel = sel;
      flash_bus_o.rd = act && !we_r && st_r != ZS_HOLD;
      flash_bus_o.wr = we_r && st_r == ZS_XFER;
      flash_bus_o.addr = addr_r;
      flash_bus_o.wdata = wdata_r;
    end else begin
      ext_bus_o.sel = sel;
      ext_bus_o.rd = act && !we_r && st_r != ZS_HOLD;
      ext_bus_o.wr = we_r && st_r == ZS_XFER;
      ext_bus_o.addr = addr_r;
      ext_bus_o.wdata = wdata_r;
    end
  end

  // Data pins are driven for the whole write, hold cycles included.
  assign ext_data_oe_n_o = !(we_r && st_r != ZS_IDLE && !(zone_r == ZN_S0 && !z0_ext));

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [4:0] cyc_cnt_r;
  logic [4:0] exp_r;

  // Counts bus clocks of the current access for the length checks.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_cnt_r <= 5'h00;
      exp_r <= 5'h00;
    end else if (accept) begin
      cyc_cnt_r <= 5'h00;
      exp_r <= exp_d;
    end else if (st_r != ZS_IDLE) begin
      cyc_cnt_r <= cyc_cnt_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cycle_length: assert property (done_r |-> cyc_cnt_r == exp_r)
    else $error("Bus cycle length differs from configured length.");
  a_fast_read_one: assert property (accept && fast_d |=> st_r == ZS_XFER ##1 st_r == ZS_IDLE)
    else $error("Fast read did not take one clock.");
  a_norm_read_two: assert property (accept && !core_req_i.we && !fast_d && wait_d == 3'h0
      && hold_d == 2'h0 && zone_d != ZN_NONE |=> st_r == ZS_ADDR ##1 st_r == ZS_XFER ##1 done_r)
    else $error("Normal read did not take two clocks.");
  a_write_length: assert property (accept && core_req_i.we && early_d && wait_d == 3'h0
      && hold_d == 2'h0 && zone_d != ZN_NONE
      |=> st_r == ZS_ADDR ##1 st_r == ZS_ADDR ##1 st_r == ZS_XFER ##1 done_r)
    else $error("Early write did not take three clocks.");
  a_wait_after_addr: assert property (st_r == ZS_ADDR && cnt_r == 3'h0 && wait_r != 3'h0
      |=> st_r == ZS_WAIT)
    else $error("Wait cycles did not follow the address phase.");
  a_hold_keeps_data: assert property (st_r == ZS_HOLD && we_r && ext_bus_o.sel != 4'h0
      |-> !ext_data_oe_n_o && $stable(ext_bus_o.wdata))
    else $error("Write data not held during hold cycles.");
  // Stall drops in the done cycle itself, so the release is checked against done.
  a_stall_till_done: assert property ($rose(core_stall_o) |-> ##[1:16] done_r)
    else $error("Core access did not complete in time.");
  a_stall_release: assert property ($fell(core_stall_o) |-> done_r)
    else $error("Core released before the cycle completed.");
  a_zone0_decode: assert property (accept |-> (zone_d == ZN_S0) == (core_req_i.addr <= Z0_HI))
    else $error("Zone 0 decode wrong.");
  a_ext_gate: assert property (mode_r == ZBU_IRE || mode_r == ZBU_ISP
      |-> !ext_bus_o.sel[SEL_Z1] && !ext_bus_o.sel[SEL_Z2])
    else $error("External zone selected in an internal mode.");
  a_dev_redirect: assert property (mode_r == ZBU_DEV && flash_bus_o.sel != 4'h0 |-> 1'b0)
    else $error("Flash selected in development mode.");
  a_isp_strap: assert property (!strap_done_r && boot_mode_pins_i == BOOT_ISP
      |=> mode_r == ZBU_ISP)
    else $error("Programming strap did not select programming mode.");
  a_cfg_reset: assert property ($past(rst_i) |-> bus_write_timing_config_r == BUS_CFG_RST
      && !zone_cfg_r[1][FAST_RD_BIT])
    else $error("Configuration reset value wrong.");

  c_fast_read: cover property (accept && fast_d);
  c_early_write: cover property (accept && early_d && zone_d != ZN_NONE);
  c_hold_cycle: cover property (st_r == ZS_HOLD && we_r);
  c_reserved: cover property (accept && zone_d == ZN_NONE);

endmodule // zbu_zone_bus_unit

/* verif/zbu_core_master.sv */
// Core bus master model: issues one word access at a time on the core port.
// Assumes the bench clock and a unit that answers with a one-cycle done pulse.
`timescale 1ns/1ps

module zbu_core_master (
  input wire logic clk_i,
  input wire logic done_i,
  input wire logic oe_n_i,
  input wire logic [15:0] rdata_i,
  input wire zbu_pkg::zbu_mem_bus_s flash_bus_i,
  input wire zbu_pkg::zbu_mem_bus_s ext_bus_i,
  output zbu_pkg::zbu_core_req_s core_req_o
);
  import zbu_pkg::*;

  // ****************************************************************
  // Access task.
  // ****************************************************************
  initial core_req_o = '0;

  // Holds the request until done, counting edges; the edge after done is left idle
  // so that back-to-back calls never drive the request twice in one time step.
  task automatic access(input logic we, input logic [23:0] addr, input logic [15:0] wd,
                        output int n, output logic [15:0] rd, output logic [3:0] es,
                        output logic fs, output logic oe_seen);
    n = 0;
    rd = 16'h0000;
    es = 4'h0;
    fs = 1'b0;
    oe_seen = 1'b0;
    // Map holes 040000h-0DFFFFh and 100000h-3FFFFFh are never issued.
    if ((addr >= 24'h04_0000 && addr <= 24'h0d_ffff) ||
        (addr >= 24'h10_0000 && addr <= 24'h3f_ffff)) begin
      n = -1;
      return;
    end
    core_req_o <= '{valid: 1'b1, we: we, addr: addr, wdata: wd};
    do begin
      @(posedge clk_i);
      n++;
      es |= ext_bus_i.sel;
      fs |= flash_bus_i.sel[0];
      if (oe_n_i === 1'b0) oe_seen = 1'b1;
    end while (done_i !== 1'b1 && n < 40);
    rd = rdata_i;
    core_req_o <= '0;
    @(posedge clk_i);
  endtask
endmodule // zbu_core_master

/* verif/zone_bus_interface_unit_tb.sv */
// Self-checking bench for the zone bus unit: register bus, boot modes, zones, timing.
// Assumes the core master model and design assertions inside the design files.
`timescale 1ns/1ps

module zone_bus_interface_unit_tb;
  import zbu_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [25:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [2:0] boot_mode_pins_i = 3'h7;
  logic flash_blank_i = 1'b0;
  zbu_core_req_s core_req_i;
  logic core_stall_o, core_done_o, ext_data_oe_n_o;
  logic [15:0] core_rdata_o;
  zbu_mem_bus_s flash_bus_o, ext_bus_o;
  logic [15:0] tick = 16'h0000;
  wire logic [15:0] flash_rdata_i;
  wire logic [15:0] ext_data_i;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int stall_n = 0;

  // ****************************************************************
  // Clock, memories and instances.
  // ****************************************************************
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) tick <= tick + 16'h0001;
  // Counts sampled stall cycles so the core hold-off length can be checked.
  always @(posedge clk_i) begin
    if (core_stall_o === 1'b1) stall_n++;
  end
  // Undriven data lines show a changing pattern so stale values never pass.
  assign flash_rdata_i = flash_bus_o.rd ? (flash_bus_o.addr[15:0] ^ 16'h5a5a) : ~tick;
  assign ext_data_i = ext_bus_o.rd ? (ext_bus_o.addr[15:0] ^ 16'hc3c3) : tick;

  zbu_zone_bus_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .boot_mode_pins_i(boot_mode_pins_i), .flash_blank_i(flash_blank_i),
    .core_req_i(core_req_i), .core_stall_o(core_stall_o), .core_done_o(core_done_o),
    .core_rdata_o(core_rdata_o), .flash_bus_o(flash_bus_o), .flash_rdata_i(flash_rdata_i),
    .ext_bus_o(ext_bus_o), .ext_data_i(ext_data_i), .ext_data_oe_n_o(ext_data_oe_n_o));

  zbu_core_master cm_u (.clk_i(clk_i), .done_i(core_done_o), .oe_n_i(ext_data_oe_n_o),
    .rdata_i(core_rdata_o), .flash_bus_i(flash_bus_o), .ext_bus_i(ext_bus_o),
    .core_req_o(core_req_i));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic close_out();
    $display("mismatches %0d of %0d checks", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      errors++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb_xfer(input logic we, input logic [23:0] idx, input logic [31:0] wd,
                         output logic [31:0] rd);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (t >= 20) chk_n(t, 1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // A pin value of 111 stands for straps left floating on their pull-ups.
  task automatic do_reset(input logic [2:0] pins, input logic blank);
    boot_mode_pins_i <= pins;
    flash_blank_i <= blank;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic test_regs();
    logic [31:0] d;
    logic [23:0] zi [4] = '{IO_CFG_IDX, SZA_CFG_IDX, SZB_CFG_IDX, SZC_CFG_IDX};
    wb_xfer(1'b0, BUS_CFG_IDX, 32'h0000_0000, d);
    chk_v(d, 32'h0000_0007);
    foreach (zi[i]) begin
      wb_xfer(1'b0, zi[i], 32'h0000_0000, d);
      chk_v(d, 32'h0000_069f);
    end
    wb_xfer(1'b1, 24'hff_f920, 32'h0000_1234, d);
    wb_xfer(1'b0, 24'hff_f920, 32'h0000_0000, d);
    chk_v(d, 32'h0000_0000);
    wb_xfer(1'b1, SZB_CFG_IDX, 32'h0000_0a5b, d);
    wb_xfer(1'b0, SZB_CFG_IDX, 32'h0000_0000, d);
    chk_v(d, 32'h0000_0a5b);
  endtask

  task automatic test_modes();
    logic [31:0] d;
    logic [2:0] pins [6] = '{3'h7, 3'h7, 3'h3, 3'h3, 3'h6, 3'h0};
    logic blank [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [1:0] md [6] = '{2'h0, 2'h3, 2'h1, 2'h3, 2'h3, 2'h2};
    foreach (pins[i]) begin
      do_reset(pins[i], blank[i]);
      wb_xfer(1'b0, MODE_STAT_IDX, 32'h0000_0000, d);
      chk_v(d, {27'h0, pins[i], md[i]});
    end
  endtask

  task automatic test_timing();
    logic [31:0] d;
    logic [15:0] rd;
    logic [3:0] es;
    logic fs, oe;
    int n, w, h, s;
    logic [15:0] cf [3] = '{16'h0000, 16'h0011, 16'h001f};
    do_reset(3'h7, 1'b0);
    s = stall_n;
    cm_u.access(1'b0, 24'h00_1234, 16'h0000, n, rd, es, fs, oe);
    chk_n(n, 2 + 7 + 3 + 2);
    chk_n(stall_n - s, 2 + 7 + 3 + 1);
    chk_v({15'h0, fs, rd}, {15'h0, 1'b1, 16'h1234 ^ 16'h5a5a});
    foreach (cf[i]) begin
      w = cf[i][2:0];
      h = cf[i][4:3];
      wb_xfer(1'b1, SZA_CFG_IDX, {16'h0, cf[i]}, d);
      s = stall_n;
      cm_u.access(1'b0, 24'h03_fffe, 16'h0000, n, rd, es, fs, oe);
      chk_n(n, 2 + w + h + 2);
      chk_n(stall_n - s, 2 + w + h + 1);
      chk_v({16'h0, rd}, {16'h0, 16'hfffe ^ 16'h5a5a});
      cm_u.access(1'b1, 24'h00_0100, 16'hbeef, n, rd, es, fs, oe);
      chk_n(n, 3 + w + h + 2);
      wb_xfer(1'b1, BUS_CFG_IDX, 32'h0000_0006, d);
      cm_u.access(1'b1, 24'h00_0100, 16'hbeef, n, rd, es, fs, oe);
      chk_n(n, 2 + w + h + 2);
      wb_xfer(1'b1, BUS_CFG_IDX, 32'h0000_0007, d);
      wb_xfer(1'b1, SZA_CFG_IDX, {16'h0, cf[i] | 16'h0800}, d);
      cm_u.access(1'b0, 24'h00_0042, 16'h0000, n, rd, es, fs, oe);
      chk_n(n, 1 + 2);
    end
    cm_u.access(1'b0, 24'h40_0000, 16'h0000, n, rd, es, fs, oe);
    chk_v({11'h0, es, fs, rd}, 32'h0000_0000);
    chk_n(n, 2);
  endtask

  task automatic test_zones();
    logic [15:0] rd;
    logic [3:0] es;
    logic fs, oe;
    int n;
    logic [23:0] ad [6] = '{24'h40_0000, 24'h7f_fffe, 24'h80_0000, 24'hfe_fffe,
                            24'hff_fb00, 24'hff_fbfe};
    logic [3:0] sl [6] = '{4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
    do_reset(3'h3, 1'b0);
    foreach (ad[i]) begin
      cm_u.access(1'b0, ad[i], 16'h0000, n, rd, es, fs, oe);
      chk_n(n, 2 + 7 + 3 + 2);
      chk_v({11'h0, es, fs, rd}, {11'h0, sl[i], 1'b0, ad[i][15:0] ^ 16'hc3c3});
    end
    cm_u.access(1'b1, 24'h40_0002, 16'h1357, n, rd, es, fs, oe);
    chk_n(n, 3 + 7 + 3 + 2);
    chk_v({27'h0, es, oe}, {27'h0, 4'h2, 1'b1});
    do_reset(3'h0, 1'b1);
    cm_u.access(1'b0, 24'h00_1000, 16'h0000, n, rd, es, fs, oe);
    chk_v({11'h0, es, fs, rd}, {11'h0, 4'h1, 1'b0, 16'h1000 ^ 16'hc3c3});
  endtask

  // ****************************************************************
  // Main sequence and timeout.
  // ****************************************************************
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    do_reset(3'h7, 1'b0);
    test_regs();
    test_modes();
    test_timing();
    test_zones();
    close_out();
  end
endmodule // zone_bus_interface_unit_tb
